// file: rtl/rss_top.sv
// Purpose: ramp/soak setpoint program sequencer with APB registers
// Assumes: measured value group comes from logic on pclk; pattern pins are asynchronous
// Notes: zero-wait APB slave; read data is captured in the setup cycle
`timescale 1ns/1ps
module rss_top #(
  parameter int CYC_SEC = rss_pkg::CYC_PER_BASE
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire rss_pkg::rss_pv_t pv, // measured value with range flags
  input wire logic [4:0] input_selected_pattern, // pattern from input pins
  input wire logic key_step, // pattern step key, level
  output logic [rss_pkg::SPW-1:0] sp_out, // program setpoint
  output rss_pkg::rss_sts_t status, // off, run, hold, end
  output logic soak_wait, // soak paused, value out of band
  output logic [5:0] step_now // current step index
);
  import rss_pkg::*;
  localparam int CSW = $clog2(CKPT_SEC + 1);

  typedef struct packed {
    rss_ctrl_t ctrl;
    logic [SPW-1:0] soak_band_upper;
    logic [SPW-1:0] soak_band_lower;
    logic [4:0] pattern_step_upper;
    logic [4:0] pattern_step_lower;
    logic [5:0] sel;
    logic [NSTEP-1:0][SPW-1:0] step_target_setpoints;
    logic [NSTEP-1:0][15:0] tr;
    logic [NSTEP-1:0][15:0] ts;
    rss_seq_t seq;
    logic [5:0] step;
    logic [5:0] idx;
    logic [5:0] mn;
    logic [5:0] mx;
    logic [15:0] left;
    logic [15:0] rtot;
    logic [SPW-1:0] rstart;
    logic [SPW-1:0] sp;
    rss_ckpt_t ckpt;
    logic [CSW-1:0] csec;
    logic [4:0] di1;
    logic [4:0] di2;
    logic [2:0] key;
    logic [31:0] rdata;
    logic err;
    logic gsw;
    rss_sts_t sts;
  } rss_st_t;

  rss_st_t s, n;
  logic sec_tick, unit_tick;
  logic [11:0] rng;
  logic [5:0] first, last, gstep, kstep, mn, mx;
  logic [4:0] pat;
  logic run, go, kgo, pwr, band_ok, key_edge, inr;
  logic [SPW-1:0] gstart, v, vp, pvv;

  // first and last step of a pattern, packed as {first, last}
  function automatic logic [11:0] span(input logic [4:0] p);
    logic [6:0] f;
    logic [6:0] c;
    if (p < 5'h10) begin
      f = 7'(p) << 2;
      c = 7'h04;
    end else if (p < 5'h18) begin
      f = 7'(p - 5'h10) << 3;
      c = 7'h08;
    end else if (p < 5'h1C) begin
      f = 7'(p - 5'h18) << 4;
      c = 7'h10;
    end else if (p < PAT_LAST_NUM) begin
      f = 7'(p - 5'h1C) << 5;
      c = 7'h20;
    end else begin
      f = 7'h00;
      c = 7'h40;
    end
    return {f[5:0], 6'(f + c - 7'h01)};
  endfunction

  // a * b / c, with zero for an empty divisor
  function automatic logic [15:0] mulfrac(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    logic [31:0] q;
    q = (c == 16'h0000) ? 32'h0000_0000 : (32'(a) * 32'(b)) / 32'(c);
    return q[15:0];
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    return (a >= b) ? a - b : b - a;
  endfunction

  // ramp value with 'left' units to go out of 'total'
  function automatic logic [15:0] interp(input logic [15:0] st, input logic [15:0] tg,
                                         input logic [15:0] left, input logic [15:0] total);
    logic [15:0] d;
    d = mulfrac(absdiff(tg, st), left, total);
    return (tg >= st) ? tg - d : tg + d;
  endfunction

  // map bus values 3 onto the safe encodings
  function automatic rss_ctrl_t wr_ctrl(input logic [15:0] w);
    rss_ctrl_t c;
    c = rss_ctrl_t'(w);
    if (w[1:0] == 2'h3) begin
      c.cmd = CMD_STOP;
    end
    if (w[9:8] == 2'h3) begin
      c.recovery = REC_STAY;
    end
    return c;
  endfunction

  rss_tick #(.CYC_SEC(CYC_SEC)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .time_sec(s.ctrl.time_sec),
    .sec_tick(sec_tick),
    .unit_tick(unit_tick)
  );

  always_comb begin
    n = s;
    pvv = pv.value;
    inr = !pv.over && !pv.under;
    // the input-selected pattern is read only through the synchroniser
    pat = (s.ctrl.pattern == PAT_DI) ? s.di2 : s.ctrl.pattern;
    rng = span((pat > PAT_LAST_NUM) ? PAT_LAST_NUM : pat);
    first = rng[11:6];
    last = rng[5:0];
    run = s.ctrl.cmd == CMD_RUN;
    // programmed setpoint, so a clamped output can starve the soak
    band_ok = ({1'b0, pvv} + {1'b0, s.soak_band_lower} >= {1'b0, s.step_target_setpoints[s.step]}) &&
              ({1'b0, pvv} <= {1'b0, s.step_target_setpoints[s.step]} + {1'b0, s.soak_band_upper});
    key_edge = s.key[1] & ~s.key[2];
    v = s.step_target_setpoints[s.idx];
    vp = s.step_target_setpoints[s.idx - 6'h01];
    mn = (v < s.step_target_setpoints[s.mn]) ? s.idx : s.mn;
    mx = (v > s.step_target_setpoints[s.mx]) ? s.idx : s.mx;
    go = 1'b0;
    gstep = first;
    gstart = pvv;
    kgo = 1'b0;
    kstep = s.step;
    pwr = 1'b0;

    // pin synchronisers
    n.di1 = input_selected_pattern;
    n.di2 = s.di1;
    n.key = {s.key[1], s.key[0], key_step};

    // apb setup cycle captures read data so the access phase needs no wait
    if (psel && !penable) begin
      n.err = 1'b0;
      n.rdata = '0;
      if (paddr == OFS_CTRL) begin
        n.rdata = 32'(s.ctrl);
      end else if (paddr == OFS_BAND) begin
        n.rdata = {s.soak_band_lower, s.soak_band_upper};
      end else if (paddr == OFS_PATB) begin
        n.rdata = {19'h0_0000, s.pattern_step_lower, 3'h0, s.pattern_step_upper};
      end else if (paddr == OFS_SEL) begin
        n.rdata = 32'(s.sel);
      end else if (paddr == OFS_STSV) begin
        n.rdata = 32'(s.step_target_setpoints[s.sel]);
      end else if (paddr == OFS_STTM) begin
        n.rdata = {s.ts[s.sel], s.tr[s.sel]};
      end else if (paddr == OFS_STAT) begin
        n.rdata = {s.left, 6'h00, s.step, s.seq == SEQ_SOAK, s.gsw, s.sts};
      end else if (paddr == OFS_SP) begin
        n.rdata = 32'(s.sp);
      end else if (paddr == OFS_CKPT) begin
        n.rdata = s.ckpt;
      end else if (paddr != OFS_EVT) begin
        n.err = 1'b1;
      end
    end

    // apb writes take effect at the access edge
    if (psel && penable && pwrite) begin
      if (paddr == OFS_CTRL) begin
        n.ctrl = wr_ctrl(pwdata[15:0]);
      end else if (paddr == OFS_BAND) begin
        n.soak_band_upper = pwdata[15:0];
        n.soak_band_lower = pwdata[31:16];
      end else if (paddr == OFS_PATB) begin
        n.pattern_step_upper = pwdata[4:0];
        n.pattern_step_lower = pwdata[12:8];
      end else if (paddr == OFS_SEL) begin
        n.sel = pwdata[5:0];
      end else if (paddr == OFS_STSV) begin
        n.step_target_setpoints[s.sel] = pwdata[15:0];
      end else if (paddr == OFS_STTM) begin
        n.tr[s.sel] = pwdata[15:0];
        n.ts[s.sel] = pwdata[31:16];
      end else if (paddr == OFS_CKPT) begin
        n.ckpt = pwdata;
        n.ckpt.rsv = '0;
      end else if (paddr == OFS_EVT) begin
        pwr = pwdata[EVT_PWRUP];
      end
    end

    // sequencer: stop wins, hold freezes step, setpoint and timer in place
    if (s.ctrl.cmd == CMD_STOP) begin
      n.seq = SEQ_IDLE;
    end else if (run) begin
      case (s.seq)
        SEQ_IDLE: begin
          if (s.ctrl.start_pv && s.ctrl.recovery != REC_RESUME) begin
            n.seq = SEQ_SEARCH;
            n.idx = first;
            n.mn = first;
            n.mx = first;
          end else begin
            go = 1'b1;
          end
        end
        SEQ_SEARCH: begin
          // one step examined per cycle, lowest step first
          n.mn = mn;
          n.mx = mx;
          n.idx = s.idx + 6'h01;
          if (inr && pvv == v) begin
            kgo = 1'b1;
            kstep = s.idx;
          end else if (inr && s.idx != first && ((pvv > vp && pvv < v) || (pvv < vp && pvv > v))) begin
            n.seq = SEQ_RAMP;
            n.step = s.idx;
            n.rstart = vp;
            n.rtot = s.tr[s.idx];
            n.left = s.tr[s.idx] - mulfrac(absdiff(pvv, vp), s.tr[s.idx], absdiff(v, vp));
            n.sp = pvv;
          end else if (s.idx == last) begin
            if (pv.under) begin
              kgo = 1'b1;
              kstep = mn;
            end else if (!pv.over && pvv < s.step_target_setpoints[mn]) begin
              go = 1'b1;
            end else begin
              kgo = 1'b1;
              kstep = mx;
            end
          end
        end
        SEQ_RAMP: begin
          if (s.left == 16'h0000) begin
            kgo = 1'b1;
          end else if (unit_tick) begin
            n.left = s.left - 16'h0001;
            n.sp = interp(s.rstart, s.step_target_setpoints[s.step], n.left, s.rtot);
          end
        end
        SEQ_SOAK: begin
          if (s.left == 16'h0000) begin
            gstart = s.step_target_setpoints[s.step];
            if (s.step != last) begin
              go = 1'b1;
              gstep = s.step + 6'h01;
            end else if (s.ctrl.method[MTH_RPT]) begin
              go = 1'b1;
            end else if (s.ctrl.method[MTH_OFF]) begin
              n.seq = SEQ_IDLE;
              n.ctrl.cmd = CMD_STOP;
            end else begin
              n.seq = SEQ_END;
            end
          end else if (unit_tick && (!s.ctrl.gs_en || band_ok)) begin
            n.left = s.left - 16'h0001;
          end
        end
        default: begin
          n.seq = s.seq; // end state holds output until stop
        end
      endcase
    end

    // power-up event after settings are loaded
    if (pwr) begin
      if (s.ctrl.recovery == REC_RESUME) begin
        if (s.ckpt.valid) begin
          n.ctrl.cmd = CMD_RUN;
          n.step = s.ckpt.step;
          n.left = s.ckpt.left;
          n.rtot = s.ckpt.left;
          n.rstart = pvv;
          n.seq = s.ckpt.soak ? SEQ_SOAK : SEQ_RAMP;
          n.sp = s.ckpt.soak ? s.step_target_setpoints[s.ckpt.step] : pvv;
        end
      end else if (s.ctrl.recovery == REC_RESTART || s.ctrl.method[MTH_PON]) begin
        n.ctrl.cmd = CMD_RUN;
        go = 1'b1;
        gstep = first;
        gstart = pvv;
      end
    end

    // common entries into a ramp or a soak
    if (go) begin
      n.seq = SEQ_RAMP;
      n.step = gstep;
      n.left = s.tr[gstep];
      n.rtot = s.tr[gstep];
      n.rstart = gstart;
      n.sp = gstart;
    end
    if (kgo) begin
      n.seq = SEQ_SOAK;
      n.step = kstep;
      n.left = s.ts[kstep];
      n.sp = s.step_target_setpoints[kstep];
    end

    // snapshot every few minutes; hardware update wins over a bus write
    if (sec_tick) begin
      n.csec = (s.csec == CSW'(CKPT_SEC - 1)) ? '0 : s.csec + 1'b1;
    end
    if (sec_tick && s.csec == CSW'(CKPT_SEC - 1) && (s.seq == SEQ_RAMP || s.seq == SEQ_SOAK)) begin
      n.ckpt.left = s.left;
      n.ckpt.rsv = '0;
      n.ckpt.valid = 1'b1;
      n.ckpt.soak = s.seq == SEQ_SOAK;
      n.ckpt.step = s.step;
    end else if (s.seq != SEQ_IDLE && n.seq == SEQ_IDLE) begin
      n.ckpt.valid = 1'b0;
    end

    // key stepping between the bounds; code 31 sits after 30
    if (key_edge && s.seq == SEQ_IDLE) begin
      n.ctrl.pattern = (s.ctrl.pattern >= s.pattern_step_upper) ? s.pattern_step_lower
                       : s.ctrl.pattern + 5'h01;
    end

    // only a soak that carries on may flag a wait, so the flag never outlives the active status
    n.gsw = s.ctrl.gs_en && s.seq == SEQ_SOAK && n.seq == SEQ_SOAK && !band_ok;
    if (n.seq == SEQ_IDLE) begin
      n.sts = STS_OFF;
    end else if (n.seq == SEQ_END) begin
      n.sts = STS_END;
    end else if (n.ctrl.cmd == CMD_HOLD) begin
      n.sts = STS_HOLD;
    end else begin
      n.sts = STS_RUN;
    end
  end

  // all state in one register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & s.err;
  assign sp_out = s.sp;
  assign status = s.sts;
  assign soak_wait = s.gsw;
  assign step_now = s.step;
endmodule

// file: rtl/rss_pkg.sv
// Purpose: shared constants and types of the ramp/soak program sequencer
// Assumes: 20 MHz pclk, APB register access, 64 program steps
// Notes: register map, control, checkpoint and value field layouts and state encodings live here
package rss_pkg;
  localparam int CLK_HZ = 20_000_000; // pclk rate
  localparam int BASE_S = 1; // shortest timer base, seconds
  localparam int CYC_PER_BASE = CLK_HZ * BASE_S;
  localparam int SEC_PER_MIN = 60;
  localparam int CKPT_MIN = 5; // snapshot age limit, minutes
  localparam int CKPT_SEC = CKPT_MIN * SEC_PER_MIN;
  localparam int NSTEP = 64;
  localparam int SPW = 16;
  localparam logic [4:0] PAT_LAST_NUM = 5'h1E; // highest numbered pattern
  localparam logic [4:0] PAT_DI = 5'h1F; // pattern taken from input pins
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAND = 8'h04;
  localparam logic [7:0] OFS_PATB = 8'h08;
  localparam logic [7:0] OFS_SEL = 8'h0C;
  localparam logic [7:0] OFS_STSV = 8'h10;
  localparam logic [7:0] OFS_STTM = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_SP = 8'h1C;
  localparam logic [7:0] OFS_CKPT = 8'h20;
  localparam logic [7:0] OFS_EVT = 8'h24;
  // run method flag positions
  localparam int MTH_RPT = 0;
  localparam int MTH_OFF = 1;
  localparam int MTH_END = 2;
  localparam int MTH_PON = 3;
  localparam int EVT_PWRUP = 0; // power-up event bit of the event register
  typedef enum logic [1:0] {CMD_STOP = 2'h0, CMD_RUN = 2'h1, CMD_HOLD = 2'h2} rss_cmd_t;
  typedef enum logic [1:0] {REC_STAY = 2'h0, REC_RESUME = 2'h1, REC_RESTART = 2'h2} rss_rec_t;
  typedef enum logic [1:0] {STS_OFF = 2'h0, STS_RUN = 2'h1, STS_HOLD = 2'h2, STS_END = 2'h3} rss_sts_t;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0, SEQ_SEARCH = 3'h1, SEQ_RAMP = 3'h3, SEQ_SOAK = 3'h2, SEQ_END = 3'h6
  } rss_seq_t;
  typedef struct packed {
    logic [4:0] pattern;
    logic time_sec;
    rss_rec_t recovery;
    logic start_pv;
    logic gs_en;
    logic [3:0] method;
    rss_cmd_t cmd;
  } rss_ctrl_t;
  typedef struct packed {
    logic [15:0] left;
    logic [7:0] rsv;
    logic valid;
    logic soak;
    logic [5:0] step;
  } rss_ckpt_t;
  typedef struct packed {
    logic [SPW-1:0] value;
    logic over;
    logic under;
  } rss_pv_t;
endpackage

// file: rtl/rss_tick.sv
// Purpose: time base for the sequencer timers
// Assumes: CYC_SEC pclk cycles make one second
// Notes: both outputs are one-cycle enable pulses
`timescale 1ns/1ps
module rss_tick #(
  parameter int CYC_SEC = rss_pkg::CYC_PER_BASE
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic time_sec, // 1: timers count seconds, 0: minutes
  output logic sec_tick, // one pulse per second
  output logic unit_tick // one pulse per timer unit
);
  import rss_pkg::*;
  localparam int CW = $clog2(CYC_SEC);
  typedef struct packed {
    logic [CW-1:0] cyc;
    logic [5:0] sec;
    logic st;
    logic ut;
  } rss_tk_t;
  rss_tk_t s, n;
  logic wrap, mwrap;

  // divider chain; the unit select only picks which pulse leaves
  always_comb begin
    n = s;
    wrap = s.cyc == CW'(CYC_SEC - 1);
    mwrap = wrap && (s.sec == 6'(SEC_PER_MIN - 1));
    n.cyc = wrap ? '0 : s.cyc + 1'b1;
    if (wrap) begin
      n.sec = mwrap ? '0 : s.sec + 6'h01;
    end
    n.st = wrap;
    n.ut = time_sec ? wrap : mwrap;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sec_tick = s.st;
  assign unit_tick = s.ut;
endmodule

// file: bench/rss_asserts.sv
// Purpose: port checks of the ramp/soak sequencer
// Assumes: apb slave with pready tied high
// Notes: a command or power-up write excuses state moves for two cycles
`timescale 1ns/1ps
module rss_asserts (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [rss_pkg::SPW-1:0] sp_out, // setpoint
  input wire rss_pkg::rss_sts_t status, // state
  input wire logic soak_wait, // soak paused
  input wire logic [5:0] step_now // step
);
  import rss_pkg::*;
  logic wr_now;
  logic [1:0] wr_d;
  // the state may move up to two cycles after the write that asks for it
  assign wr_now = psel && penable && pwrite && (paddr == OFS_CTRL || paddr == OFS_EVT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_d <= 2'b00;
    else wr_d <= {wr_d[0], wr_now};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in transfer");
  property p_err_phase; pslverr |-> psel && penable; endproperty
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
  property p_err_map; psel && penable && paddr > OFS_EVT |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped address not refused");
  property p_rd_stands; psel && penable |=> $stable(prdata); endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data moved in access");
  property p_hold_frz; status == STS_HOLD ##1 status == STS_HOLD |=> $stable(sp_out) && $stable(step_now); endproperty
  a_hold_frz: assert property (p_hold_frz) else $error("held program moved");
  property p_hold_stay; status == STS_HOLD && !wr_now && wr_d == 2'b00 |=> status == STS_HOLD; endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("hold left without command");
  property p_end_stay; status == STS_END && !wr_now && wr_d == 2'b00 |=> status == STS_END && $stable(sp_out); endproperty
  a_end_stay: assert property (p_end_stay) else $error("end state not kept");
  property p_off_stay; status == STS_OFF && !wr_now && wr_d == 2'b00 |=> status == STS_OFF; endproperty
  a_off_stay: assert property (p_off_stay) else $error("stopped state left unasked");
  property p_wait_act; soak_wait |-> status == STS_RUN || status == STS_HOLD; endproperty
  a_wait_act: assert property (p_wait_act) else $error("soak wait while not active");
endmodule
bind rss_top rss_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .sp_out, .status, .soak_wait, .step_now);

// file: bench/rss_meas_model.sv
// Purpose: measured value and operator key source
// Assumes: requests come from the bench
// Notes: outputs move only after an edge, like a sampled sensor
`timescale 1ns/1ps
module rss_meas_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire rss_pkg::rss_pv_t pv_req, // wanted measurement
  input wire logic key_req, // wanted key level
  output rss_pkg::rss_pv_t pv, // measurement out
  output logic key_step // key level out
);
  import rss_pkg::*;
  // registering avoids glitches on the sequencer inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pv <= '0;
      key_step <= 1'b0;
    end else begin
      pv <= pv_req;
      key_step <= key_req;
    end
  end
endmodule

// file: bench/rss_top_tb.sv
// Purpose: self-checking bench of the ramp/soak sequencer
// Assumes: CYC_SEC cut to 20, so a timer second is 20 cycles
// Notes: steps 0..3 of pattern 0 hold the test program
`timescale 1ns/1ps
module rss_top_tb;
  import rss_pkg::*;
  localparam int U = 20; // cycles per timer second
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  rss_pv_t pv_req = '0;
  rss_pv_t pv;
  logic key_req = 1'b0;
  logic key_step;
  logic [4:0] pins = 5'h07;
  logic [15:0] sp_out;
  rss_sts_t status;
  logic soak_wait;
  logic [5:0] step_now;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] rdv;
  logic err;
  logic [15:0] held;
  rss_ctrl_t c;
  // value in bits 17:2, over and under in bits 1:0
  logic [17:0] tpv [7] = '{18'h004B0, 18'h00258, 18'h000C8, 18'h007D0, 18'h00002, 18'h00001, 18'h004B0};
  logic [9:0] texp [7] = '{10'h029, 10'h011, 10'h001, 10'h039, 10'h039, 10'h009, 10'h001};
  always #25 pclk = ~pclk;
  rss_top #(.CYC_SEC(U)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pv, .input_selected_pattern(pins), .key_step, .sp_out, .status, .soak_wait, .step_now);
  rss_meas_model pm (.pclk, .presetn, .pv_req, .key_req, .pv, .key_step);
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // cut a hang short; the whole run needs about 1500 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // one apb transfer; answer taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    check(what, rdv & m, exp);
  endtask
  task automatic ctl(input rss_cmd_t cmd, input logic [3:0] m);
    c.cmd = cmd;
    c.method = m;
    wr(OFS_CTRL, {16'h0000, c});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // sel 0 status, 1 step, 2 soak wait; bounded wait then compare
  task automatic wait_for(input int sel, input logic [7:0] v, input int max);
    int n;
    logic [7:0] cur;
    n = 0;
    forever begin
      cur = (sel == 0) ? {6'h00, status} : (sel == 1) ? {2'h0, step_now} : {7'h00, soak_wait};
      if (cur === v || n >= max) break;
      @(posedge pclk);
      n++;
    end
    check("wait", 32'(cur), 32'(v));
  endtask
  task automatic press();
    key_req <= 1'b1;
    idle(8);
    key_req <= 1'b0;
    idle(8);
  endtask
  initial begin
    c = '0;
    c.time_sec = 1'b1;
    idle(5);
    presetn <= 1'b1;
    rc("ctrl reset", OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rc("stat reset", OFS_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(OFS_BAND, 32'h0005_0005);
    rc("band", OFS_BAND, 32'h0005_0005, 32'hFFFF_FFFF);
    // zero ramp time on the last step
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SEL, 32'(i));
      wr(OFS_STSV, 32'h64 * 32'(i + 1));
      wr(OFS_STTM, (i == 3) ? 32'h0002_0000 : 32'h0002_0002);
    end
    rc("step sv", OFS_STSV, 32'h0000_0190, 32'hFFFF_FFFF);
    apb(1'b0, 8'h28, 32'h0000_0000);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rdv, 32'h0);
    $display("done: registers");
    ctl(CMD_RUN, 4'h4);
    idle(12 * U);
    check("still running", 32'(status), 32'(STS_RUN));
    wait_for(0, 8'(STS_END), 5 * U);
    idle(2 * U);
    check("end sp", 32'(sp_out), 32'h190);
    check("end step", 32'(step_now), 32'h3);
    ctl(CMD_STOP, 4'h4);
    ctl(CMD_RUN, 4'h2);
    idle(12 * U);
    wait_for(0, 8'(STS_OFF), 5 * U);
    rc("cmd cleared", OFS_CTRL, 32'h0, 32'h3);
    ctl(CMD_RUN, 4'h5);
    wait_for(1, 8'h03, 16 * U);
    wait_for(1, 8'h00, 4 * U);
    check("repeat runs", 32'(status), 32'(STS_RUN));
    ctl(CMD_STOP, 4'h4);
    $display("done: run methods");
    ctl(CMD_RUN, 4'h4);
    idle(U);
    ctl(CMD_HOLD, 4'h4);
    idle(3);
    held = sp_out;
    idle(3 * U);
    check("held sp", 32'(sp_out), 32'(held));
    check("held", 32'(status), 32'(STS_HOLD));
    ctl(CMD_RUN, 4'h4);
    idle(3);
    check("resumed", 32'(status), 32'(STS_RUN));
    ctl(CMD_STOP, 4'h4);
    c.gs_en = 1'b1;
    pv_req <= {16'h03E8, 2'b00};
    ctl(CMD_RUN, 4'h4);
    wait_for(2, 8'h01, 5 * U);
    idle(3 * U);
    check("soak paused", 32'(step_now), 32'h0);
    pv_req <= {16'h0064, 2'b00};
    wait_for(2, 8'h00, 6);
    wait_for(1, 8'h01, 3 * U);
    ctl(CMD_STOP, 4'h4);
    c.gs_en = 1'b0;
    $display("done: hold and soak");
    for (int i = 0; i < 7; i++) begin
      pv_req <= tpv[i];
      c.start_pv = (i != 6);
      ctl(CMD_RUN, 4'h4);
      idle(8);
      rc("search", OFS_STAT, 32'(texp[i]), 32'h3FF);
      ctl(CMD_STOP, 4'h4);
    end
    $display("done: start from value");
    c.start_pv = 1'b0;
    pv_req <= {16'h00C8, 2'b00};
    ctl(CMD_STOP, 4'h8);
    wr(OFS_EVT, 32'h1);
    wait_for(0, 8'(STS_RUN), 10);
    // look before the first timer tick can move the ramp
    check("power-on sp", 32'(sp_out), 32'hC8);
    ctl(CMD_STOP, 4'h0);
    wr(OFS_EVT, 32'h1);
    idle(10);
    check("stay stopped", 32'(status), 32'(STS_OFF));
    c.recovery = REC_RESTART;
    ctl(CMD_STOP, 4'h0);
    wr(OFS_EVT, 32'h1);
    wait_for(0, 8'(STS_RUN), 10);
    check("restart step", 32'(step_now), 32'h0);
    ctl(CMD_STOP, 4'h0);
    c.recovery = REC_RESUME;
    c.start_pv = 1'b1;
    pv_req <= {16'h0064, 2'b00};
    ctl(CMD_STOP, 4'h0);
    wr(OFS_CKPT, 32'h0002_00C2);
    wr(OFS_EVT, 32'h1);
    idle(8);
    rc("resume", OFS_STAT, 32'h029, 32'h3FF);
    ctl(CMD_STOP, 4'h0);
    // value equals step 0, so a search would start its soak; resume mode must skip it
    ctl(CMD_RUN, 4'h0);
    idle(8);
    rc("no search in resume", OFS_STAT, 32'h001, 32'h3FF);
    ctl(CMD_STOP, 4'h0);
    c.recovery = REC_STAY;
    c.start_pv = 1'b0;
    ctl(CMD_STOP, 4'h0);
    $display("done: power-up");
    // upper bound is the input selection, so stepping passes 30 on to it
    wr(OFS_PATB, 32'h0000_1D1F);
    c.pattern = PAT_LAST_NUM;
    ctl(CMD_STOP, 4'h0);
    press();
    rc("key to pins", OFS_CTRL, 32'(PAT_DI) << 11, 32'hF800);
    press();
    rc("key wrap", OFS_CTRL, 32'h1D << 11, 32'hF800);
    $display("done: key stepping");
    finish_test();
  end
endmodule
